// File: rtl/timer_duration_regs.sv
// Overview of operation
// - Each timer's pulse lasts its raw duration count times the shared time base.
// - A raw duration count is only accepted in the range 1 to 4095.
// - The time base is in microseconds, resets to 1 and changes in steps of 1.
// - One time base serves all four timers.
// - Raw and absolute duration writes go only to the timer picked by the selector.
// - The absolute duration is in microseconds, in multiples of the time base.
// - Writing an absolute duration stores the matching raw count using the current base.
// - Reading the absolute duration gives raw count times time base for the selected timer.
// - The absolute view follows any raw change at once.
// - The single-line level reads 1 when the selected line is high and 0 when low.
// - The all-lines word is 32 bits with a 1 for each high line.
// - After trigger and delay, a timer drives high for the duration then low.
// - Only exposure start can start a timer.
module timer_duration_regs #(
	parameter int CYCLES_PER_US = timer_cfg_pkg::CYC_PER_US
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic awvalid,
	output logic awready,
	input wire logic [timer_cfg_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	// AXI4-Lite write data
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// AXI4-Lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read address
	input wire logic arvalid,
	output logic arready,
	input wire logic [timer_cfg_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	// AXI4-Lite read data
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Camera events and lines
	input wire logic exp_start,
	input wire logic [timer_cfg_pkg::IN_LINES-1:0] line_in,
	output logic [timer_cfg_pkg::NUM_TMR-1:0] line_out
);

	localparam int NT = timer_cfg_pkg::NUM_TMR;
	localparam int RW = timer_cfg_pkg::RAW_W;
	localparam int BW = timer_cfg_pkg::BASE_W;
	localparam int PW = RW + BW;
	localparam int NL = timer_cfg_pkg::NUM_LINES;

	typedef struct packed {
		logic awh;
		logic [timer_cfg_pkg::ADDR_W-1:0] awa;
		logic wh;
		logic [31:0] wd;
		logic [3:0] ws;
		logic bv;
		logic [1:0] br;
		logic rv;
		logic [31:0] rd;
		logic [1:0] rr;
		logic div;
		logic [5:0] dcnt;
		logic [BW-1:0] drem;
		logic [32:0] dquo;
		logic [timer_cfg_pkg::TSEL_W-1:0] sel;
		logic [timer_cfg_pkg::LSEL_W-1:0] lsel;
		logic [BW-1:0] base;
		logic [NT-1:0][RW-1:0] raw;
		logic [NT-1:0][RW-1:0] dly;
		logic [7:0] ucnt;
		logic tick;
		logic [timer_cfg_pkg::IN_LINES-1:0] in_s1;
		logic [timer_cfg_pkg::IN_LINES-1:0] in_s2;
	} regs_t;

	regs_t q;
	regs_t d;
	logic [NT-1:0] tmr_out;
	logic [NT-1:0][PW-1:0] dur_us;
	logic [NL-1:0] lvl;
	logic [31:0] lvl_all;
	logic lvl_sel;
	logic [32:0] wr_old;
	logic [32:0] rd_now;
	logic [31:0] merged;
	logic [16:0] rem_sh;
	logic rem_ge;
	logic [32:0] quo_n;
	logic [RW-1:0] quo_clamp;

	// ***************************************************
	// Timers and line levels
	// ***************************************************
	genvar gi;
	generate
		for (gi = 0; gi < NT; gi++) begin : g_tmr
			// Shared base applied to every timer
			assign dur_us[gi] = PW'(q.raw[gi]) * PW'(q.base);
			pulse_timer #(
				.DUR_W(PW),
				.DLY_W(RW)
			) u_timer (
				.aclk(aclk),
				.aresetn(aresetn),
				.us_tick(q.tick),
				.exp_start(exp_start),
				.delay_us(q.dly[gi]),
				.dur_us(dur_us[gi]),
				.pulse_out(tmr_out[gi])
			);
			assign lvl[timer_cfg_pkg::IN_LINES + gi] = tmr_out[gi];
			assign lvl_all[timer_cfg_pkg::LVL_OUT_LSB + gi] = tmr_out[gi];
		end
		for (gi = 0; gi < timer_cfg_pkg::IN_LINES; gi++) begin : g_in
			assign lvl[gi] = q.in_s2[gi];
			assign lvl_all[timer_cfg_pkg::LVL_IN_LSB + gi] = q.in_s2[gi];
		end
		for (gi = 0; gi < 32; gi++) begin : g_pad
			if (!((gi >= timer_cfg_pkg::LVL_IN_LSB && gi < timer_cfg_pkg::LVL_IN_LSB
				+ timer_cfg_pkg::IN_LINES) || (gi >= timer_cfg_pkg::LVL_OUT_LSB
				&& gi < timer_cfg_pkg::LVL_OUT_LSB + NT))) begin : g_zero
				assign lvl_all[gi] = 1'b0;
			end
		end
	endgenerate

	assign line_out = tmr_out;
	// Selected line level, zero past the last line
	assign lvl_sel = (32'(q.lsel) < NL) ? lvl[q.lsel] : 1'b0;

	// ***************************************************
	// Register read mux
	// ***************************************************
	// Returns {mapped, value} for one address
	function automatic logic [32:0] reg_read(input logic [timer_cfg_pkg::ADDR_W-1:0] a,
		input regs_t s, input logic [PW-1:0] dur_sel, input logic lv,
		input logic [31:0] lall);
		logic [32:0] r;
		r = {1'b0, 32'h0000_0000};
		unique case (a)
			timer_cfg_pkg::OFF_TMR_SEL: r = {1'b1, 30'h0, s.sel};
			timer_cfg_pkg::OFF_DUR_RAW: r = {1'b1, 20'h0, s.raw[s.sel]};
			timer_cfg_pkg::OFF_DUR_BASE: r = {1'b1, 16'h0, s.base};
			timer_cfg_pkg::OFF_DUR_ABS: r = {1'b1, 4'h0, dur_sel};
			timer_cfg_pkg::OFF_DLY_RAW: r = {1'b1, 20'h0, s.dly[s.sel]};
			timer_cfg_pkg::OFF_LINE_SEL: r = {1'b1, 29'h0, s.lsel};
			timer_cfg_pkg::OFF_LINE_LVL: r = {1'b1, 31'h0, lv};
			timer_cfg_pkg::OFF_LINE_ALL: r = {1'b1, lall};
			default: r = {1'b0, 32'h0000_0000};
		endcase
		return r;
	endfunction : reg_read

	// Byte-lane merge of new data over the old value
	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] st);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				m[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return m;
	endfunction : lane_merge

	assign wr_old = reg_read(q.awa, q, dur_us[q.sel], lvl_sel, lvl_all);
	assign rd_now = reg_read(araddr, q, dur_us[q.sel], lvl_sel, lvl_all);
	assign merged = lane_merge(wr_old[31:0], q.wd, q.ws);

	// One restoring divide step for absolute-to-raw conversion
	assign rem_sh = {q.drem, q.dquo[32]};
	assign rem_ge = rem_sh >= {1'b0, q.base};
	assign quo_n = {q.dquo[31:0], rem_ge};
	assign quo_clamp = (quo_n > 33'(timer_cfg_pkg::RAW_MAX)) ? timer_cfg_pkg::RAW_MAX :
		(quo_n == 33'h0_0000_0000) ? timer_cfg_pkg::RAW_MIN : quo_n[RW-1:0];

	// AXI handshakes from held state
	assign awready = !q.awh && !q.bv && !q.div;
	assign wready = !q.wh && !q.bv && !q.div;
	assign arready = !q.rv;
	assign bvalid = q.bv;
	assign bresp = q.br;
	assign rvalid = q.rv;
	assign rdata = q.rd;
	assign rresp = q.rr;

	// ***************************************************
	// Next-state logic
	// ***************************************************
	always_comb begin
		d = q;
		// Microsecond enable and input synchroniser
		d.tick = 1'b0;
		if (32'(q.ucnt) >= CYCLES_PER_US - 1) begin
			d.ucnt = 8'h00;
			d.tick = 1'b1;
		end else begin
			d.ucnt = q.ucnt + 8'h01;
		end
		d.in_s1 = line_in;
		d.in_s2 = q.in_s1;
		// Write channel capture, either order
		if (q.bv && bready) begin
			d.bv = 1'b0;
		end
		if (awvalid && awready) begin
			d.awh = 1'b1;
			d.awa = awaddr;
		end
		if (wvalid && wready) begin
			d.wh = 1'b1;
			d.wd = wdata;
			d.ws = wstrb;
		end
		// Register update once both halves are held
		if (q.awh && q.wh && !q.div && !q.bv) begin
			d.awh = 1'b0;
			d.wh = 1'b0;
			d.bv = 1'b1;
			d.br = timer_cfg_pkg::RESP_OKAY;
			unique case (q.awa)
				timer_cfg_pkg::OFF_TMR_SEL: begin
					if (merged < 32'(NT)) begin
						d.sel = merged[timer_cfg_pkg::TSEL_W-1:0];
					end else begin
						d.br = timer_cfg_pkg::RESP_SLVERR;
					end
				end
				timer_cfg_pkg::OFF_DUR_RAW: begin
					if (merged >= 32'(timer_cfg_pkg::RAW_MIN)
						&& merged <= 32'(timer_cfg_pkg::RAW_MAX)) begin
						d.raw[q.sel] = merged[RW-1:0];
					end else begin
						d.br = timer_cfg_pkg::RESP_SLVERR;
					end
				end
				timer_cfg_pkg::OFF_DUR_BASE: begin
					if (merged != 32'h0000_0000 && merged < (32'h0000_0001 << BW)) begin
						d.base = merged[BW-1:0];
					end else begin
						d.br = timer_cfg_pkg::RESP_SLVERR;
					end
				end
				timer_cfg_pkg::OFF_DUR_ABS: begin
					// Round to nearest: add half a base before dividing
					d.bv = 1'b0;
					d.div = 1'b1;
					d.wd = merged;
					d.dcnt = 6'(timer_cfg_pkg::DIV_STEPS);
					d.drem = '0;
					d.dquo = {1'b0, merged} + {18'h0_0000, q.base[BW-1:1]};
				end
				timer_cfg_pkg::OFF_DLY_RAW: begin
					if (merged <= 32'(timer_cfg_pkg::RAW_MAX)) begin
						d.dly[q.sel] = merged[RW-1:0];
					end else begin
						d.br = timer_cfg_pkg::RESP_SLVERR;
					end
				end
				timer_cfg_pkg::OFF_LINE_SEL: begin
					if (merged < 32'(NL)) begin
						d.lsel = merged[timer_cfg_pkg::LSEL_W-1:0];
					end else begin
						d.br = timer_cfg_pkg::RESP_SLVERR;
					end
				end
				default: begin
					d.br = timer_cfg_pkg::RESP_SLVERR;
				end
			endcase
		end
		// Divider runs one quotient bit per cycle
		if (q.div) begin
			d.drem = rem_ge ? 16'(rem_sh - {1'b0, q.base}) : rem_sh[BW-1:0];
			d.dquo = quo_n;
			d.dcnt = q.dcnt - 6'h01;
			if (q.dcnt == 6'h01) begin
				d.div = 1'b0;
				d.bv = 1'b1;
				d.br = timer_cfg_pkg::RESP_OKAY;
				d.raw[q.sel] = quo_clamp;
			end
		end
		// Read channel
		if (q.rv && rready) begin
			d.rv = 1'b0;
		end
		if (arvalid && arready) begin
			d.rv = 1'b1;
			d.rd = rd_now[31:0];
			d.rr = rd_now[32] ? timer_cfg_pkg::RESP_OKAY : timer_cfg_pkg::RESP_SLVERR;
		end
	end

	// State register with reset values
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
			q.base <= timer_cfg_pkg::BASE_RST_US;
			q.raw <= {NT{timer_cfg_pkg::RAW_RST}};
			q.dly <= {NT{timer_cfg_pkg::DLY_RST}};
		end else begin
			q <= d;
		end
	end

	// ***************************************************
	// Assertions
	// ***************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic [PW-1:0] abs_now;
	logic [32:0] abs_err;
	assign abs_now = dur_us[q.sel];
	assign abs_err = (33'(abs_now) > 33'(q.wd)) ? 33'(abs_now) - 33'(q.wd) :
		33'(q.wd) - 33'(abs_now);

	base_reset_a: assert property ($rose(aresetn) |-> q.base == timer_cfg_pkg::BASE_RST_US)
		else $error("time base not one after reset");
	base_nonzero_a: assert property (q.base != '0)
		else $error("time base reached zero");
	abs_read_a: assert property (arvalid && arready && araddr == timer_cfg_pkg::OFF_DUR_ABS
		|=> rdata == 32'($past(abs_now)))
		else $error("absolute read is not raw times base");
	div_done_a: assert property ($rose(q.div) |-> ##[33:34] (!q.div && q.bv))
		else $error("absolute conversion did not finish in time");
	abs_round_a: assert property ($fell(q.div) |-> (abs_err <= 33'(q.base[BW-1:1]))
		|| q.raw[q.sel] == timer_cfg_pkg::RAW_MIN || q.raw[q.sel] == timer_cfg_pkg::RAW_MAX)
		else $error("absolute conversion not rounded to nearest");
	line_one_a: assert property (arvalid && arready && araddr == timer_cfg_pkg::OFF_LINE_LVL
		|=> rdata == {31'h0, $past(lvl_sel)})
		else $error("single line level mismatch");
	line_all_a: assert property (arvalid && arready && araddr == timer_cfg_pkg::OFF_LINE_ALL
		|=> rdata[31:8] == 24'h00_0000 && rdata[3:2] == 2'h0 && rdata == $past(lvl_all))
		else $error("all-lines word mismatch");
	bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped before taken");

	generate
		for (gi = 0; gi < NT; gi++) begin : g_chk
			raw_range_a: assert property (q.raw[gi] >= timer_cfg_pkg::RAW_MIN)
				else $error("raw duration left its range");
			sel_only_a: assert property ($changed(q.raw[gi]) |-> $past(q.sel) == gi)
				else $error("raw written to an unselected timer");
		end
	endgenerate

	abs_write_c: cover property ($fell(q.div) ##[1:8] (bvalid && bready));
	all_read_c: cover property (arvalid && arready && araddr == timer_cfg_pkg::OFF_LINE_ALL);
	base_write_c: cover property ($changed(q.base));

endmodule : timer_duration_regs

// File: common/timer_cfg_pkg.sv
package timer_cfg_pkg;

	// ***************************************************
	// Register map (byte addresses)
	// ***************************************************
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_TMR_SEL = 8'h00;
	localparam logic [7:0] OFF_DUR_RAW = 8'h04;
	localparam logic [7:0] OFF_DUR_BASE = 8'h08;
	localparam logic [7:0] OFF_DUR_ABS = 8'h0C;
	localparam logic [7:0] OFF_DLY_RAW = 8'h10;
	localparam logic [7:0] OFF_LINE_SEL = 8'h14;
	localparam logic [7:0] OFF_LINE_LVL = 8'h18;
	localparam logic [7:0] OFF_LINE_ALL = 8'h1C;

	// ***************************************************
	// Field widths, limits and reset values
	// ***************************************************
	localparam int NUM_TMR = 4;
	localparam int TSEL_W = 2;
	localparam int RAW_W = 12;
	localparam logic [11:0] RAW_MIN = 12'h001;
	localparam logic [11:0] RAW_MAX = 12'hFFF;
	localparam logic [11:0] RAW_RST = 12'h001;
	localparam logic [11:0] DLY_RST = 12'h000;
	localparam int BASE_W = 16;
	localparam logic [15:0] BASE_RST_US = 16'h0001;
	localparam int IN_LINES = 2;
	localparam int NUM_LINES = IN_LINES + NUM_TMR;
	localparam int LSEL_W = 3;
	localparam int LVL_IN_LSB = 0;
	localparam int LVL_OUT_LSB = 4;
	localparam int DIV_STEPS = 33;

	// ***************************************************
	// Timing
	// ***************************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int US_NS = 1000;
	localparam int CYC_PER_US = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ***************************************************
	// AXI responses
	// ***************************************************
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : timer_cfg_pkg

// File: rtl/pulse_timer.sv
module pulse_timer #(
	parameter int DUR_W = 28,
	parameter int DLY_W = 12
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Time base and trigger
	input wire logic us_tick,
	input wire logic exp_start,
	// Settings in microseconds
	input wire logic [DLY_W-1:0] delay_us,
	input wire logic [DUR_W-1:0] dur_us,
	// Timer output
	output logic pulse_out
);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DELAY = 2'b01,
		ST_ACTIVE = 2'b10
	} pt_state_t;

	typedef struct packed {
		pt_state_t st;
		logic pulse;
		logic [DUR_W-1:0] cnt;
		logic [DUR_W-1:0] dur;
		logic [DLY_W-1:0] dly;
	} pt_regs_t;

	pt_regs_t q;
	pt_regs_t d;
	logic [DUR_W-1:0] cnt_inc;

	assign cnt_inc = q.cnt + DUR_W'(1);
	assign pulse_out = q.pulse;

	// Delay then active phase, settings latched at start
	always_comb begin
		d = q;
		unique case (q.st)
			ST_IDLE: begin
				if (exp_start) begin
					d.dur = dur_us;
					d.dly = delay_us;
					d.cnt = '0;
					if (delay_us == '0) begin
						d.st = ST_ACTIVE;
						d.pulse = 1'b1;
					end else begin
						d.st = ST_DELAY;
					end
				end
			end
			ST_DELAY: begin
				if (us_tick) begin
					if (cnt_inc == DUR_W'(q.dly)) begin
						d.st = ST_ACTIVE;
						d.pulse = 1'b1;
						d.cnt = '0;
					end else begin
						d.cnt = cnt_inc;
					end
				end
			end
			ST_ACTIVE: begin
				if (us_tick) begin
					if (cnt_inc == q.dur) begin
						d.st = ST_IDLE;
						d.pulse = 1'b0;
						d.cnt = '0;
					end else begin
						d.cnt = cnt_inc;
					end
				end
			end
			default: begin
				d.st = ST_IDLE;
				d.pulse = 1'b0;
			end
		endcase
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ***************************************************
	// Assertions
	// ***************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	start_event_a: assert property ((q.st == ST_IDLE) ##1 (q.st != ST_IDLE) |-> $past(exp_start))
		else $error("timer left idle without exposure start");
	pulse_end_a: assert property ($fell(q.pulse) |-> $past(us_tick) && ($past(cnt_inc) == $past(q.dur)))
		else $error("pulse ended before its duration");
	pulse_hold_a: assert property (q.pulse && !us_tick |=> q.pulse)
		else $error("pulse dropped between ticks");
	pulse_cover_c: cover property ($rose(q.pulse) ##[1:1000] $fell(q.pulse));

endmodule : pulse_timer

// File: testbench/timer_duration_and_line_status_tb.sv
module timer_duration_and_line_status_tb;
	timeunit 1ns;
	timeprecision 1ns;

	// ***************************************************
	// Signals
	// ***************************************************
	localparam int CPU = 2;
	localparam int LIM = 400;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, exp_start;
	logic awready, wready, bvalid, arready, rvalid;
	logic [timer_cfg_pkg::ADDR_W-1:0] awaddr, araddr;
	logic [2:0] awprot, arprot;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [timer_cfg_pkg::IN_LINES-1:0] line_in;
	logic [timer_cfg_pkg::NUM_TMR-1:0] line_out;
	int fails, n_compared;

	// Design under test, short microsecond for a fast run
	timer_duration_regs #(.CYCLES_PER_US(CPU)) u_timer_duration_regs (
		.aclk(aclk), .aresetn(aresetn),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.exp_start(exp_start), .line_in(line_in), .line_out(line_out)
	);

	// Clock, 100 ns period
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// ***************************************************
	// Shared tasks
	// ***************************************************
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %0h seen %0h", name, exp, got);
		end
	endtask : chk

	task automatic hang(input string name, input int n);
		if (n >= LIM) begin
			fails++;
			$display("MISMATCH %s expected answer seen timeout", name);
			complete_run();
		end
	endtask : hang

	// One AXI4-Lite write, response code compared
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		logic ap, wp, bk;
		logic [1:0] r;
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		ap = 1'b1;
		wp = 1'b1;
		bk = 1'b0;
		n = 0;
		while ((ap || wp) && n < LIM) begin
			@(negedge aclk);
			if (awready) ap = 1'b0;
			if (wready) wp = 1'b0;
			@(posedge aclk);
			if (!ap) awvalid <= 1'b0;
			if (!wp) wvalid <= 1'b0;
			n++;
		end
		while (!bk && n < LIM) begin
			@(negedge aclk);
			bk = bvalid;
			r = bresp;
			@(posedge aclk);
			n++;
		end
		bready <= 1'b0;
		hang("bvalid", n);
		chk("bresp", {30'h0, er}, {30'h0, r});
	endtask : wr

	// One AXI4-Lite read, response code compared
	task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
		logic ap, rk;
		logic [1:0] r;
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		ap = 1'b1;
		rk = 1'b0;
		n = 0;
		while (ap && n < LIM) begin
			@(negedge aclk);
			if (arready) ap = 1'b0;
			@(posedge aclk);
			if (!ap) arvalid <= 1'b0;
			n++;
		end
		while (!rk && n < LIM) begin
			@(negedge aclk);
			rk = rvalid;
			r = rresp;
			v = rdata;
			@(posedge aclk);
			n++;
		end
		rready <= 1'b0;
		hang("rvalid", n);
		chk("rresp", {30'h0, er}, {30'h0, r});
	endtask : rd

	// ***************************************************
	// Scenarios
	// ***************************************************
	task automatic t_reset();
		chk("line_out idle", 32'h0, {28'h0, line_out});
		rd(timer_cfg_pkg::OFF_DUR_BASE, d, 2'h0);
		chk("base reset", 32'h1, d);
		rd(timer_cfg_pkg::OFF_DUR_RAW, d, 2'h0);
		chk("raw reset", 32'h1, d);
		rd(timer_cfg_pkg::OFF_DUR_ABS, d, 2'h0);
		chk("abs reset", 32'h1, d);
	endtask : t_reset

	task automatic t_raw_range();
		wr(timer_cfg_pkg::OFF_DUR_RAW, 32'h0, 2'h2);
		rd(timer_cfg_pkg::OFF_DUR_RAW, d, 2'h0);
		chk("raw after zero", 32'h1, d);
		wr(timer_cfg_pkg::OFF_DUR_RAW, 32'hFFF, 2'h0);
		wr(timer_cfg_pkg::OFF_DUR_RAW, 32'h1000, 2'h2);
		rd(timer_cfg_pkg::OFF_DUR_RAW, d, 2'h0);
		chk("raw max kept", 32'hFFF, d);
		wr(timer_cfg_pkg::OFF_DUR_RAW, 32'h1, 2'h0);
	endtask : t_raw_range

	task automatic t_select_base();
		wr(timer_cfg_pkg::OFF_TMR_SEL, 32'h2, 2'h0);
		wr(timer_cfg_pkg::OFF_DUR_RAW, 32'h64, 2'h0);
		wr(timer_cfg_pkg::OFF_TMR_SEL, 32'h0, 2'h0);
		rd(timer_cfg_pkg::OFF_DUR_RAW, d, 2'h0);
		chk("raw other timer", 32'h1, d);
		wr(timer_cfg_pkg::OFF_DUR_BASE, 32'h0, 2'h2);
		wr(timer_cfg_pkg::OFF_DUR_BASE, 32'h3, 2'h0);
		rd(timer_cfg_pkg::OFF_DUR_ABS, d, 2'h0);
		chk("abs timer0", 32'h3, d);
		wr(timer_cfg_pkg::OFF_DUR_RAW, 32'h5, 2'h0);
		rd(timer_cfg_pkg::OFF_DUR_ABS, d, 2'h0);
		chk("abs follows raw", 32'hF, d);
		wr(timer_cfg_pkg::OFF_TMR_SEL, 32'h2, 2'h0);
		rd(timer_cfg_pkg::OFF_DUR_ABS, d, 2'h0);
		chk("abs timer2", 32'h12C, d);
	endtask : t_select_base

	task automatic t_abs();
		wr(timer_cfg_pkg::OFF_TMR_SEL, 32'h0, 2'h0);
		wr(timer_cfg_pkg::OFF_DUR_ABS, 32'h1E, 2'h0);
		rd(timer_cfg_pkg::OFF_DUR_RAW, d, 2'h0);
		chk("raw from abs", 32'hA, d);
		wr(timer_cfg_pkg::OFF_DUR_ABS, 32'h7, 2'h0);
		rd(timer_cfg_pkg::OFF_DUR_RAW, d, 2'h0);
		chk("raw round down", 32'h2, d);
		wr(timer_cfg_pkg::OFF_DUR_ABS, 32'h8, 2'h0);
		rd(timer_cfg_pkg::OFF_DUR_ABS, d, 2'h0);
		chk("abs round up", 32'h9, d);
		wr(timer_cfg_pkg::OFF_TMR_SEL, 32'h2, 2'h0);
		rd(timer_cfg_pkg::OFF_DUR_RAW, d, 2'h0);
		chk("raw timer2 kept", 32'h64, d);
	endtask : t_abs

	// Timer 1: raw 2 at base 3 gives 6 us high
	task automatic t_pulse();
		int n, cnt;
		wr(timer_cfg_pkg::OFF_TMR_SEL, 32'h1, 2'h0);
		wr(timer_cfg_pkg::OFF_DUR_RAW, 32'h2, 2'h0);
		// Two-tick delay keeps the launch edge clear of the first sample
		wr(timer_cfg_pkg::OFF_DLY_RAW, 32'h2, 2'h0);
		@(posedge aclk);
		exp_start <= 1'b1;
		@(posedge aclk);
		exp_start <= 1'b0;
		n = 0;
		while (line_out[1] !== 1'b1 && n < LIM) begin
			@(negedge aclk);
			n++;
		end
		hang("pulse start", n);
		chk("delay ok", 32'h1, {31'h0, n >= 2 * CPU && n <= 2 * CPU + 1});
		cnt = 0;
		while (line_out[1] === 1'b1 && cnt < LIM) begin
			@(negedge aclk);
			cnt++;
		end
		chk("pulse length ok", 32'h1, {31'h0, cnt >= 5 * CPU && cnt <= 6 * CPU + 1});
		chk("pulse ends low", 32'h0, {31'h0, line_out[1]});
	endtask : t_pulse

	task automatic t_lines();
		int n;
		@(posedge aclk);
		line_in <= 2'b10;
		repeat (4) @(posedge aclk);
		// Wait until only the long timer 2 pulse is still high
		n = 0;
		while (line_out !== 4'b0100 && n < LIM) begin
			@(negedge aclk);
			n++;
		end
		hang("timer2 alone", n);
		rd(timer_cfg_pkg::OFF_LINE_ALL, d, 2'h0);
		chk("all lines busy", 32'h42, d);
		wr(timer_cfg_pkg::OFF_LINE_SEL, 32'h4, 2'h0);
		rd(timer_cfg_pkg::OFF_LINE_LVL, d, 2'h0);
		chk("timer2 level", 32'h1, d);
		// Let every timer return low
		n = 0;
		while (line_out !== 4'b0000 && n < LIM) begin
			repeat (2) @(negedge aclk);
			n++;
		end
		hang("timers idle", n);
		rd(timer_cfg_pkg::OFF_LINE_LVL, d, 2'h0);
		chk("timer2 low", 32'h0, d);
		rd(timer_cfg_pkg::OFF_LINE_ALL, d, 2'h0);
		chk("all lines", 32'h2, d);
		wr(timer_cfg_pkg::OFF_LINE_SEL, 32'h1, 2'h0);
		rd(timer_cfg_pkg::OFF_LINE_LVL, d, 2'h0);
		chk("line1 level", 32'h1, d);
		wr(timer_cfg_pkg::OFF_LINE_SEL, 32'h0, 2'h0);
		rd(timer_cfg_pkg::OFF_LINE_LVL, d, 2'h0);
		chk("line0 level", 32'h0, d);
		wr(timer_cfg_pkg::OFF_LINE_SEL, 32'h6, 2'h2);
		wr(timer_cfg_pkg::OFF_LINE_LVL, 32'h1, 2'h2);
		rd(8'h20, d, 2'h2);
	endtask : t_lines

	// ***************************************************
	// Main sequence
	// ***************************************************
	initial begin
		fails = 0;
		n_compared = 0;
		aresetn = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		exp_start = 1'b0;
		awaddr = 8'h00;
		araddr = 8'h00;
		awprot = 3'h0;
		arprot = 3'h0;
		wdata = 32'h0;
		wstrb = 4'hF;
		line_in = 2'b00;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_raw_range();
		t_select_base();
		t_abs();
		t_pulse();
		t_lines();
		complete_run();
	end

endmodule : timer_duration_and_line_status_tb
